// ==== ota_update_pkg.sv ====
// Package with constants and carrier types for the dual-bank update controller
package ota_update_pkg;
  // Frame identifiers and payload codes
  localparam logic [10:0] id_start = 11'h100;
  localparam logic [10:0] id_data = 11'h110;
  localparam logic [10:0] id_request = 11'h111;
  localparam logic [10:0] id_done = 11'h121;
  localparam logic [7:0] code_start = 8'h00;
  localparam logic [7:0] code_request = 8'h11;
  localparam logic [7:0] code_done = 8'h22;
  localparam logic [6:0] len_cmd = 7'h01;
  localparam logic [6:0] len_data = 7'h40;
  // Link channel and bit-rate settings, reported by the controller
  localparam logic [1:0] link_channel = 2'h1;
  localparam int nominal_rate_bps = 1000000;
  localparam int data_rate_bps = 2000000;
  localparam logic [1:0] accept_rule_count = 2'h2;
  // Address map (byte addresses)
  localparam logic [31:0] bank_a_user_base = 32'h0000_0000;
  localparam logic [31:0] bank_b_user_base = 32'h0200_0000;
  localparam logic [31:0] bank_a_boot_base = 32'h0800_0000;
  localparam logic [31:0] bank_b_boot_base = 32'h0A00_0000;
  localparam logic [31:0] user_size = 32'h0001_8000;
  localparam logic [31:0] boot_size = 32'h0001_0000;
  localparam logic [31:0] bank_offset = 32'h0200_0000;
  // Block sizing
  localparam logic [9:0] block_bytes = 10'h200;
  localparam logic [3:0] frames_per_block = 4'h8;
  localparam logic [7:0] blocks_total = 8'hC0;
  localparam logic [3:0] word_bytes = 4'h4;
  localparam logic [7:0] words_per_block = 8'h80;
  localparam logic [4:0] words_per_frame = 5'h10;
  localparam logic [2:0] erase_last_block = 3'h5;

  typedef struct packed {
    logic [10:0] id;
    logic [6:0] len;
    logic [511:0] data;
  } frame_type;

  typedef enum logic [1:0] {
    op_none = 2'b00,
    op_program = 2'b01,
    op_erase = 2'b10
  } flash_op_type;

  typedef struct packed {
    flash_op_type op;
    logic [31:0] addr;
    logic [31:0] wdata;
  } flash_req_type;
endpackage

// ==== ota_bank_guard.sv ====
// Bank concurrency and protection checker for flash operation requests
`timescale 1ns/1ps
`default_nettype none
module ota_bank_guard
(
  input wire logic [31:0] addr,
  input wire ota_update_pkg::flash_op_type op,
  input wire logic running_bank_b,
  input wire logic busy,
  input wire logic suspended,
  input wire logic busy_bank_b,
  input wire ota_update_pkg::flash_op_type busy_op,
  output logic allow
);
  logic target_b;
  logic in_user;
  logic in_boot;
  always_comb
  begin
    target_b = (addr >= ota_update_pkg::bank_offset);
    in_user = target_b ?
      (addr - ota_update_pkg::bank_b_user_base) < ota_update_pkg::user_size :
      (addr - ota_update_pkg::bank_a_user_base) < ota_update_pkg::user_size;
    in_boot = (addr >= ota_update_pkg::bank_a_boot_base);
    allow = 1'b0;
    if (op != ota_update_pkg::op_none && in_user && !in_boot
        && target_b != running_bank_b)
    begin
      if (!busy)
        allow = 1'b1;
      else if (suspended && busy_bank_b != target_b)
      begin
        // Program or erase to another bank while the other is suspended
        if (busy_op == ota_update_pkg::op_erase)
          allow = 1'b1;
        else if (busy_op == ota_update_pkg::op_program)
          allow = 1'b1;
      end
    end
  end
endmodule // ota_bank_guard
`default_nettype wire

// ==== ota_update_ctrl.sv ====
// Dual-bank over-the-air update controller driven by link command frames
`timescale 1ns/1ps
`default_nettype none
module ota_update_ctrl
(
  input wire logic clock,
  input wire logic srst,
  input wire logic boot_bank_b,
  input wire ota_update_pkg::frame_type rx_frame,
  input wire logic rx_valid,
  output ota_update_pkg::frame_type tx_frame,
  output logic tx_valid,
  input wire logic tx_ready,
  output logic [1:0] link_channel,
  output logic [1:0] accept_rules,
  output logic [31:0] nominal_rate,
  output logic [31:0] data_rate,
  output ota_update_pkg::flash_req_type flash_req,
  output logic flash_req_valid,
  input wire logic flash_done,
  input wire logic data_erase_req,
  output logic data_erase_grant,
  input wire logic data_erase_done,
  output logic flash_suspend,
  output logic data_read_enable,
  output logic option_write,
  output logic option_boot_b,
  input wire logic option_done,
  output logic running_bank_b,
  output logic [31:0] map_base_front,
  output logic [31:0] map_base_back,
  output logic update_busy,
  output logic update_done
);
  typedef enum logic [3:0] {
    st_idle = 4'b0000,
    st_erase = 4'b0001,
    st_erase_wait = 4'b0010,
    st_erase_susp = 4'b0011,
    st_request = 4'b0100,
    st_receive = 4'b0101,
    st_program = 4'b0110,
    st_prog_wait = 4'b0111,
    st_option = 4'b1000,
    st_finish = 4'b1001,
    st_done = 4'b1010,
    st_send_req = 4'b1011,
    st_send_done = 4'b1100
  } state_type;

  state_type state;
  state_type next_state;
  logic boot_b;
  logic next_boot_b;
  logic [2:0] erase_blk;
  logic [2:0] next_erase_blk;
  logic [7:0] blocks;
  logic [7:0] next_blocks;
  logic [3:0] frames;
  logic [3:0] next_frames;
  logic [7:0] word_idx;
  logic [7:0] next_word_idx;
  logic [31:0] buffer [0:127];
  logic allow_q;
  logic next_allow_q;
  logic op_held;
  logic held_bank_b;
  logic [31:0] erase_addr;
  logic [31:0] prog_addr;
  ota_update_pkg::frame_type next_tx_frame;
  ota_update_pkg::flash_req_type next_flash_req;
  logic allow;
  logic [31:0] back_base;
  logic is_start;
  logic is_data;
  logic captured;

  // Boot bank caught once at reset release; mapping holds until the next reset
  always_comb
  begin
    next_boot_b = boot_b;
    if (srst)
      next_boot_b = boot_bank_b;
  end

  always_ff @(posedge clock)
  begin
    boot_b <= next_boot_b;
  end

  assign running_bank_b = boot_b;
  // Physical bank behind the shared logical window; software addresses never change
  assign map_base_front = boot_b ? ota_update_pkg::bank_b_user_base :
                          ota_update_pkg::bank_a_user_base;
  assign map_base_back = boot_b ? ota_update_pkg::bank_a_user_base :
                         ota_update_pkg::bank_b_user_base;
  assign back_base = map_base_back;
  assign link_channel = ota_update_pkg::link_channel;
  assign nominal_rate = 32'(ota_update_pkg::nominal_rate_bps);
  assign data_rate = 32'(ota_update_pkg::data_rate_bps);
  assign accept_rules = ota_update_pkg::accept_rule_count;
  assign data_read_enable = 1'b1;

  // Start match: identifier, length and payload must all agree; data frames match identifier and length only
  assign is_start = rx_valid && rx_frame.id == ota_update_pkg::id_start
    && rx_frame.len == ota_update_pkg::len_cmd
    && rx_frame.data[511:504] == ota_update_pkg::code_start;
  assign is_data = rx_valid && rx_frame.id == ota_update_pkg::id_data
    && rx_frame.len == ota_update_pkg::len_data;

  // A suspended code erase is the only operation held open across a request
  assign op_held = (state == st_erase_susp);
  assign held_bank_b = (flash_req.addr >= ota_update_pkg::bank_offset);
  // Target addresses, always inside the back bank's user region
  assign erase_addr = back_base + {15'h0000, erase_blk, 14'h0000};
  assign prog_addr = back_base + {15'h0000, blocks, 9'h000} + {22'h0, word_idx, 2'b00};

  ota_bank_guard guard
  (
    .addr(next_flash_req.addr),
    .op(next_flash_req.op),
    .running_bank_b(boot_b),
    .busy(op_held),
    .suspended(op_held),
    .busy_bank_b(held_bank_b),
    .busy_op(flash_req.op),
    .allow(allow)
  );

  assign captured = (state == st_receive) && is_data;

  // Block buffer in internal RAM, 16 words per frame
  always_ff @(posedge clock)
  begin
    if (captured)
    begin
      for (int i = 0; i < int'(ota_update_pkg::words_per_frame); i++)
        buffer[{frames[2:0], 4'(i)}] <= rx_frame.data[511 - 32 * i -: 32];
    end
  end

  always_comb
  begin
    next_state = state;
    next_erase_blk = erase_blk;
    next_blocks = blocks;
    next_frames = frames;
    next_word_idx = word_idx;
    next_tx_frame = tx_frame;
    next_flash_req = flash_req;
    case (state)
      st_idle:
      begin
        // Only an exact start command leaves idle
        if (is_start)
        begin
          next_state = st_erase;
          next_erase_blk = 3'h0;
          next_blocks = 8'h00;
        end
      end
      st_erase:
      begin
        next_flash_req.op = ota_update_pkg::op_erase;
        next_flash_req.addr = erase_addr;
        next_flash_req.wdata = 32'h0;
        next_state = st_erase_wait;
      end
      st_erase_wait:
      begin
        // Data flash erase takes priority over the code erase in flight
        if (data_erase_req)
          next_state = st_erase_susp;
        else if (flash_done)
        begin
          if (erase_blk == ota_update_pkg::erase_last_block)
            next_state = st_request;
          else
          begin
            next_erase_blk = erase_blk + 3'h1;
            next_state = st_erase;
          end
        end
      end
      st_erase_susp:
      begin
        if (data_erase_done)
          next_state = st_erase_wait;
      end
      st_request:
      begin
        if (blocks == ota_update_pkg::blocks_total)
          next_state = st_option;
        else
        begin
          next_tx_frame.id = ota_update_pkg::id_request;
          next_tx_frame.len = ota_update_pkg::len_cmd;
          next_tx_frame.data = {ota_update_pkg::code_request, 504'h0};
          next_frames = 4'h0;
          next_state = st_send_req;
        end
      end
      st_send_req:
      begin
        // Request frame stands until the host takes it
        if (tx_ready)
          next_state = st_receive;
      end
      st_receive:
      begin
        // Sixteen words per frame; the eighth frame completes the block
        if (is_data)
        begin
          next_frames = frames + 4'h1;
          if (frames == ota_update_pkg::frames_per_block - 4'h1)
          begin
            next_word_idx = 8'h00;
            next_state = st_program;
          end
        end
      end
      st_program:
      begin
        next_flash_req.op = ota_update_pkg::op_program;
        next_flash_req.addr = prog_addr;
        next_flash_req.wdata = buffer[word_idx[6:0]];
        next_state = st_prog_wait;
      end
      st_prog_wait:
      begin
        if (flash_done)
        begin
          // Block count moves only once its last word is programmed
          if (word_idx == ota_update_pkg::words_per_block - 8'h01)
          begin
            next_blocks = blocks + 8'h01;
            next_state = st_request;
          end
          else
          begin
            next_word_idx = word_idx + 8'h01;
            next_state = st_program;
          end
        end
      end
      st_option:
      begin
        // Boot select is written once, after the last block
        if (option_done)
          next_state = st_finish;
      end
      st_finish:
      begin
        next_tx_frame.id = ota_update_pkg::id_done;
        next_tx_frame.len = ota_update_pkg::len_cmd;
        next_tx_frame.data = {ota_update_pkg::code_done, 504'h0};
        next_state = st_send_done;
      end
      st_send_done:
      begin
        // Completion frame stands until the host takes it
        if (tx_ready)
          next_state = st_done;
      end
      st_done:
      begin
        next_state = st_done;
      end
      default:
      begin
        next_state = st_idle;
      end
    endcase
    if (srst)
    begin
      next_state = st_idle;
      next_erase_blk = 3'h0;
      next_blocks = 8'h00;
      next_frames = 4'h0;
      next_word_idx = 8'h00;
      next_tx_frame = '0;
      next_flash_req = '0;
    end
  end

  always_ff @(posedge clock)
  begin
    state <= next_state;
    erase_blk <= next_erase_blk;
    blocks <= next_blocks;
    frames <= next_frames;
    word_idx <= next_word_idx;
    tx_frame <= next_tx_frame;
    flash_req <= next_flash_req;
  end

  // Strobes derive from state; flash request only issued when guard allows
  assign tx_valid = (state == st_send_req) || (state == st_send_done);
  assign flash_req_valid = (state == st_erase_wait || state == st_prog_wait)
    && allow_q;
  assign flash_suspend = (state == st_erase_susp);
  assign data_erase_grant = (state == st_erase_susp);
  assign option_write = (state == st_option);
  assign option_boot_b = !boot_b;
  assign update_busy = (state != st_idle) && (state != st_done);
  assign update_done = (state == st_done);

  // Guard verdict registered alongside the request it judged
  always_comb
  begin
    next_allow_q = srst ? 1'b0 : allow;
  end

  always_ff @(posedge clock)
  begin
    allow_q <= next_allow_q;
  end
endmodule // ota_update_ctrl
`default_nettype wire

// ==== ota_update_assertions.sv ====
// Port checker for the dual-bank update controller
`timescale 1ns/1ps
`default_nettype none
module ota_update_assertions
(
  input wire logic clock,
  input wire logic srst,
  input wire ota_update_pkg::frame_type rx_frame,
  input wire logic rx_valid,
  input wire ota_update_pkg::frame_type tx_frame,
  input wire logic tx_valid,
  input wire logic [1:0] link_channel,
  input wire logic [1:0] accept_rules,
  input wire logic [31:0] nominal_rate,
  input wire logic [31:0] data_rate,
  input wire logic data_read_enable,
  input wire ota_update_pkg::flash_req_type flash_req,
  input wire logic flash_req_valid,
  input wire logic option_write,
  input wire logic option_boot_b,
  input wire logic running_bank_b,
  input wire logic [31:0] map_base_front,
  input wire logic [31:0] map_base_back,
  input wire logic update_busy
);
  default clocking @(posedge clock); endclocking
  default disable iff (srst);
  a_link_setup:
    assert property (data_read_enable && link_channel == 2'h1 && accept_rules == 2'h2
      && nominal_rate == 32'h000F4240 && data_rate == 32'h001E8480) else $error("link setup");
  a_bank_map:
    assert property (map_base_front == {6'h00, running_bank_b, 25'h0}
      && map_base_back == {6'h00, !running_bank_b, 25'h0}) else $error("bank map");
  a_bank_fixed:
    assert property (!$past(srst) |-> $stable(running_bank_b)) else $error("bank moved");
  a_start_erase:
    assert property (rx_valid && !update_busy && {rx_frame.id, rx_frame.len,
      rx_frame.data[511:504]} == {11'h100, 7'h01, 8'h00}
      |-> ##2 flash_req_valid && flash_req.op == ota_update_pkg::op_erase) else $error("no erase");
  a_back_only:
    assert property (flash_req_valid |-> flash_req.addr - map_base_back < 32'h0001_8000)
      else $error("write outside back area");
  a_tx_codes:
    assert property (tx_valid |-> {tx_frame.id, tx_frame.len, tx_frame.data[511:504]}
      inside {{11'h111, 7'h01, 8'h11}, {11'h121, 7'h01, 8'h22}}) else $error("tx frame");
  a_req_idle:
    assert property (tx_valid |-> !flash_req_valid) else $error("request while busy");
  a_boot_swap:
    assert property (option_write |-> option_boot_b != running_bank_b) else $error("no swap");
endmodule // ota_update_assertions
bind ota_update_ctrl ota_update_assertions chk_u (.clock, .srst, .rx_frame, .rx_valid,
  .tx_frame, .tx_valid, .link_channel, .accept_rules, .nominal_rate, .data_rate,
  .data_read_enable, .flash_req, .flash_req_valid, .option_write, .option_boot_b,
  .running_bank_b, .map_base_front, .map_base_back, .update_busy);
`default_nettype wire

// ==== ota_host_model.sv ====
// Update host model: start frames, answers to data requests, completion count
`timescale 1ns/1ps
`default_nettype none
module ota_host_model
(
  input wire logic clock,
  input wire logic srst,
  input wire logic go,
  input wire logic bad,
  input wire logic slow,
  input wire ota_update_pkg::frame_type tx_frame,
  input wire logic tx_valid,
  output ota_update_pkg::frame_type rx_frame,
  output logic rx_valid,
  output logic tx_ready,
  output logic [7:0] reqs,
  output logic [7:0] dones
);
  logic [3:0] nfr;
  logic [2:0] wt;
  logic [7:0] blk;
  ota_update_pkg::frame_type frm;

  // Word w of a block carries the block number and w
  always_comb
  begin
    frm = {11'h110, 7'h40, 512'h0};
    for (int i = 0; i < 16; i++)
      frm.data[511 - 32 * i -: 32] = {8'h00, blk, 9'h000, 3'(8 - nfr), 4'(i)};
  end

  always_ff @(posedge clock)
  begin
    rx_valid <= 1'b0;
    rx_frame <= srst ? '0 : ~rx_frame;
    if (srst)
    begin
      {tx_ready, wt, nfr, blk, reqs, dones} <= '0;
    end
    else if (go)
    begin
      rx_frame <= {11'h100, 7'h01, bad ? 8'h01 : 8'h00, 504'h0};
      rx_valid <= 1'b1;
    end
    else if (nfr != 4'h0)
    begin
      rx_frame <= frm;
      rx_valid <= 1'b1;
      nfr <= nfr - 4'h1;
    end
    else if (tx_valid && tx_ready)
    begin
      tx_ready <= 1'b0;
      wt <= 3'h0;
      blk <= reqs;
      nfr <= {tx_frame.id == 11'h111, 3'h0};
      reqs <= reqs + 8'(tx_frame.id == 11'h111);
      dones <= dones + 8'(tx_frame.id == 11'h121);
    end
    else if (tx_valid)
    begin
      wt <= wt + 3'h1;
      tx_ready <= !slow || wt == 3'h4;
    end
  end
endmodule // ota_host_model
`default_nettype wire

// ==== tb_top.sv ====
// Self-checking testbench for the dual-bank update controller
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic clock = 1'b0, srst = 1'b1, boot_bank_b = 1'b0, go = 1'b0, bad = 1'b0, slow = 1'b1;
  logic hold = 1'b0, flash_done = 1'b0, option_done = 1'b0;
  logic data_erase_req = 1'b0, data_erase_done = 1'b0;
  logic rx_valid, tx_valid, tx_ready, flash_req_valid, data_erase_grant, flash_suspend;
  logic option_write, option_boot_b, running_bank_b, update_busy, update_done, seen_b;
  logic [7:0] reqs, dones;
  logic [31:0] map_base_front, back;
  ota_update_pkg::frame_type rx_frame, tx_frame;
  ota_update_pkg::flash_req_type flash_req;
  int error_cnt = 0, checks_done = 0, ecnt = 0, pcnt = 0, opt_cnt = 0, n;

  always #50 clock = ~clock;

  ota_update_ctrl dut_u
  (
    .clock, .srst, .boot_bank_b, .rx_frame, .rx_valid, .tx_frame, .tx_valid, .tx_ready,
    .link_channel(), .accept_rules(), .nominal_rate(), .data_rate(), .flash_req,
    .flash_req_valid, .flash_done, .data_erase_req, .data_erase_grant, .data_erase_done,
    .flash_suspend, .data_read_enable(), .option_write, .option_boot_b, .option_done,
    .running_bank_b, .map_base_front, .map_base_back(), .update_busy, .update_done
  );
  ota_host_model host_u
  (
    .clock, .srst, .go, .bad, .slow, .tx_frame, .tx_valid, .rx_frame, .rx_valid, .tx_ready,
    .reqs, .dones
  );

  task automatic check_val(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // Flash and option store: one answer per request, none while suspended
  always @(negedge clock)
  begin
    flash_done <= 1'b0;
    option_done <= option_write && !option_done;
    if (flash_req_valid && !flash_done && !flash_suspend && !hold)
    begin
      flash_done <= 1'b1;
      if (flash_req.op == ota_update_pkg::op_erase)
      begin
        check_val("erase addr", back + 32'(ecnt) * 32'h4000, flash_req.addr);
        ecnt <= ecnt + 1;
      end
      else
      begin
        check_val("prog addr", back + 32'(pcnt) * 32'h4, flash_req.addr);
        check_val("prog data", {16'(pcnt / 128), 16'(pcnt % 128)}, flash_req.wdata);
        pcnt <= pcnt + 1;
      end
    end
    if (option_write && !option_done)
    begin
      seen_b <= option_boot_b;
      opt_cnt <= opt_cnt + 1;
    end
  end

  task automatic do_reset(input logic bank);
    srst <= 1'b1;
    boot_bank_b <= bank;
    ecnt <= 0;
    pcnt <= 0;
    opt_cnt <= 0;
    back <= bank ? 32'h0 : 32'h0200_0000;
    repeat (12) @(negedge clock);
    srst <= 1'b0;
  endtask

  task automatic send_start(input logic wrong);
    bad <= wrong;
    go <= 1'b1;
    @(negedge clock);
    go <= 1'b0;
  endtask

  task automatic test_refuse();
    check_val("front base", 32'h0, map_base_front);
    send_start(1'b1);
    repeat (10) @(negedge clock);
    check_val("refused", 0, 32'({update_busy, flash_req_valid, reqs, ecnt != 0}));
    $display("refuse test done");
  endtask

  task automatic test_full();
    send_start(1'b0);
    for (n = 0; n < 50 && ecnt < 2; n++)
      @(negedge clock);
    hold <= 1'b1;
    data_erase_req <= 1'b1;
    for (n = 0; n < 50 && data_erase_grant !== 1'b1; n++)
      @(negedge clock);
    check_val("suspend", 32'h3, 32'({data_erase_grant, flash_suspend}));
    data_erase_done <= 1'b1;
    data_erase_req <= 1'b0;
    hold <= 1'b0;
    @(negedge clock);
    data_erase_done <= 1'b0;
    for (n = 0; n < 56000 && (update_done !== 1'b1 || dones == 0); n++)
      @(negedge clock);
    check_val("programs", 192 * 128, pcnt);
    check_val("erases", 6, ecnt);
    check_val("requests", 192, reqs);
    check_val("done frames", 1, dones);
    check_val("boot swap", 32'h3, 32'({opt_cnt == 1, seen_b}));
    check_val("running bank", 0, running_bank_b);
    $display("full update test done");
  endtask

  task automatic test_bank_b();
    do_reset(1'b1);
    check_val("front base b", 32'h0200_0000, map_base_front);
    slow <= 1'b0;
    send_start(1'b0);
    for (n = 0; n < 60 && ecnt < 6; n++)
      @(negedge clock);
    check_val("bank b erases", 6, ecnt);
    for (n = 0; n < 100 && pcnt < 16; n++)
      @(negedge clock);
    check_val("bank b requests", 1, reqs);
    check_val("bank b words", 1, 32'(pcnt >= 16));
    $display("bank b test done");
  endtask

  initial
  begin
    repeat (60000) @(posedge clock);
    error_cnt++;
    close_out();
  end

  initial
  begin
    do_reset(1'b0);
    test_refuse();
    test_full();
    test_bank_b();
    close_out();
  end
endmodule // tb_top
`default_nettype wire
